/* logic/tcrb_pkg.sv */
/*
 package for the capture/reload/baud timer: register indices, byte
 addresses, field layouts, reset values and prescale counts.
 assumes a 32-bit avalon-mm master with word-aligned byte addressing.
*/
package tcrb_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// printed offsets are register indices; byte address is index * 4
	localparam logic [7:0] IDX_IRQ_EN   = 8'hA8;
	localparam logic [7:0] IDX_CTRL     = 8'hC8;
	localparam logic [7:0] IDX_MODE     = 8'hC9;
	localparam logic [7:0] IDX_RLD_LOW  = 8'hCA;
	localparam logic [7:0] IDX_RLD_HIGH = 8'hCB;
	localparam logic [7:0] IDX_CNT_LOW  = 8'hCC;
	localparam logic [7:0] IDX_CNT_HIGH = 8'hCD;

	localparam logic [ADDR_W-1:0] ADR_IRQ_EN   = {IDX_IRQ_EN, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CTRL     = {IDX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_MODE     = {IDX_MODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_RLD_LOW  = {IDX_RLD_LOW, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_RLD_HIGH = {IDX_RLD_HIGH, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CNT_LOW  = {IDX_CNT_LOW, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CNT_HIGH = {IDX_CNT_HIGH, 2'b00};

	// overflow interrupt enable position in the interrupt enable register
	localparam int IRQ_EN_BIT = 5;

	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [23:0] READ_PAD   = 24'h00_0000;

	// prescale: divided core clock for timing, faster in baud/clock-out
	localparam logic [3:0] DIV_TIMER = 4'hB;
	localparam logic [3:0] DIV_FAST  = 4'h1;
	localparam logic [3:0] DIV_ZERO  = 4'h0;

	typedef struct packed {
		logic overflow_flag;
		logic ext_trigger_flag;
		logic rx_baud_select;
		logic tx_baud_select;
		logic ext_trigger_enable;
		logic run_control;
		logic count_source_select;
		logic capture_not_reload;
	} tcrb_ctrl_t;

	typedef struct packed {
		logic [5:0] reserved;
		logic       clock_out_enable;
		logic       down_count_enable;
	} tcrb_mode_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} tcrb_avs_req_t;

	localparam tcrb_ctrl_t CTRL_RESET = 8'h00;
	localparam tcrb_mode_t MODE_RESET = 8'h00;
	localparam logic [5:0] MODE_RESV  = 6'h00;

endpackage

/* logic/tcrb_top.sv */
/*
 16-bit timer/counter with capture/reload, up/down count, baud tick
 generation and clock output, reached over avalon-mm with waitrequest.
 assumes pins arrive asynchronously; the other timer's overflow pulse
 comes from logic on clk_in.
*/
`timescale 1ns/1ps
// Contract
// - overflow sets sticky flag until software clears
// - no overflow flag while any baud select
// - trigger flag set by capturing/reloading trigger edge
// - trigger flag raises no interrupt in up/down
// - receive baud select picks receive tick source
// - transmit baud select picks transmit tick source
// - trigger edge captures/reloads except in baud or up/down mode
// - trigger disabled: pin edges ignored
// - count only while run control set
// - source select: prescaled clock or pin edges
// - capture mode copies count into reload pair
// - baud mode forces auto-reload on overflow
// - clock-out enable drives clock onto count pin; the code drives it only with source select clear
// - down count enable makes up/down counter
// - low reload register loads/captures low byte
// - high reload register loads/captures high byte
// - low count register reads/writes low byte
// - high count register reads/writes high byte
// - interrupt only with overflow interrupt enable
module tcrb_top (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	// avalon-mm slave
	input  wire tcrb_pkg::tcrb_avs_req_t     avs_req_in,
	output logic [tcrb_pkg::DATA_W-1:0]      avs_readdata_out,
	output logic                             avs_waitrequest_out,
	// pins
	input  wire logic                        ext_trigger_pin_in,
	input  wire logic                        ext_count_input_in,
	output logic                             ext_count_out,
	output logic                             ext_count_oe_n_out,
	// serial port side
	input  wire logic                        other_timer_ovf_in,
	output logic                             rx_baud_tick_out,
	output logic                             tx_baud_tick_out,
	// interrupt request
	output logic                             irq_out
);

	tcrb_pkg::tcrb_ctrl_t ctrl_reg;
	tcrb_pkg::tcrb_mode_t mode_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [7:0]  rld_low_reg;
	logic [7:0]  rld_high_reg;
	logic        irq_en_reg;
	logic        wait_reg;
	logic [tcrb_pkg::DATA_W-1:0] rdata_reg;
	logic        trig_s1_reg, trig_s2_reg, trig_prev_reg;
	logic        cin_s1_reg, cin_s2_reg, cin_prev_reg;
	logic [3:0]  pre_reg;
	logic        clk_o_reg, oe_n_reg, rx_tick_reg, tx_tick_reg, irq_reg;

	logic        baud, clk_out_mode, updown, trig_fall, cin_fall, pre_tick;
	logic        count_tick, trig_ev, ovf_ev, wr_go;
	logic [15:0] rld;
	logic [3:0]  pre_top;

	assign rld          = {rld_high_reg, rld_low_reg};
	assign baud         = ctrl_reg.rx_baud_select | ctrl_reg.tx_baud_select;
	assign clk_out_mode = mode_reg.clock_out_enable & ~ctrl_reg.count_source_select;
	assign updown       = mode_reg.down_count_enable & ~baud;
	assign trig_fall    = trig_prev_reg & ~trig_s2_reg;
	assign cin_fall     = cin_prev_reg & ~cin_s2_reg;
	assign pre_top      = (baud | clk_out_mode) ? tcrb_pkg::DIV_FAST : tcrb_pkg::DIV_TIMER;
	assign pre_tick     = (pre_reg == pre_top);
	assign wr_go        = avs_req_in.write & ~wait_reg;

	// pin synchronisers; edge detect compares the second stage with its one-cycle delayed copy
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trig_s1_reg   <= 1'b1;
			trig_s2_reg   <= 1'b1;
			trig_prev_reg <= 1'b1;
			cin_s1_reg    <= 1'b1;
			cin_s2_reg    <= 1'b1;
			cin_prev_reg  <= 1'b1;
		end else begin
			trig_s1_reg   <= ext_trigger_pin_in;
			trig_s2_reg   <= trig_s1_reg;
			trig_prev_reg <= trig_s2_reg;
			cin_s1_reg    <= ext_count_input_in;
			cin_s2_reg    <= cin_s1_reg;
			cin_prev_reg  <= cin_s2_reg;
		end
	end

	// prescaler for the divided core clock
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_reg <= tcrb_pkg::DIV_ZERO;
		end else if (pre_tick || pre_reg > pre_top) begin
			pre_reg <= tcrb_pkg::DIV_ZERO;
		end else begin
			pre_reg <= pre_reg + 4'h1;
		end
	end

	assign count_tick = ctrl_reg.run_control &
		(ctrl_reg.count_source_select ? cin_fall : pre_tick);
	// trigger gated by enable and baud; pin is direction in up/down
	assign trig_ev = ctrl_reg.ext_trigger_enable & trig_fall & ~baud & ~updown;

	always_comb begin
		cnt_next = cnt_reg;
		ovf_ev   = 1'b0;
		if (count_tick) begin
			// down count, pin high counts up
			if (updown && !trig_s2_reg) begin
				if (cnt_reg == rld) begin
					cnt_next = tcrb_pkg::CNT_MAX;
					ovf_ev   = 1'b1;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end else if (cnt_reg == tcrb_pkg::CNT_MAX) begin
				ovf_ev = 1'b1;
				if (ctrl_reg.capture_not_reload && !baud && !updown) begin
					cnt_next = tcrb_pkg::CNT_ZERO;
				end else begin
					cnt_next = rld;
				end
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
		if (trig_ev && !ctrl_reg.capture_not_reload) begin
			cnt_next = rld;
		end
		if (wr_go && avs_req_in.address == tcrb_pkg::ADR_CNT_LOW) begin
			cnt_next[7:0] = avs_req_in.writedata[7:0];
		end
		if (wr_go && avs_req_in.address == tcrb_pkg::ADR_CNT_HIGH) begin
			cnt_next[15:8] = avs_req_in.writedata[7:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= tcrb_pkg::CNT_ZERO;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// reload pair; a capture wins over a same-cycle write
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rld_low_reg  <= tcrb_pkg::BYTE_ZERO;
			rld_high_reg <= tcrb_pkg::BYTE_ZERO;
		end else if (trig_ev && ctrl_reg.capture_not_reload) begin
			rld_low_reg  <= cnt_reg[7:0];
			rld_high_reg <= cnt_reg[15:8];
		end else if (wr_go) begin
			if (avs_req_in.address == tcrb_pkg::ADR_RLD_LOW) begin
				rld_low_reg <= avs_req_in.writedata[7:0];
			end else if (avs_req_in.address == tcrb_pkg::ADR_RLD_HIGH) begin
				rld_high_reg <= avs_req_in.writedata[7:0];
			end
		end
	end

	// control register; hardware set beats software clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= tcrb_pkg::CTRL_RESET;
		end else begin
			if (wr_go && avs_req_in.address == tcrb_pkg::ADR_CTRL) begin
				ctrl_reg <= tcrb_pkg::tcrb_ctrl_t'(avs_req_in.writedata[7:0]);
			end
			if (ovf_ev && !baud) begin
				ctrl_reg.overflow_flag <= 1'b1;
			end
			if (trig_ev) begin
				ctrl_reg.ext_trigger_flag <= 1'b1;
			end else if (ovf_ev && updown) begin
				// toggles at each wrap, whether counting up or down
				ctrl_reg.ext_trigger_flag <= ~ctrl_reg.ext_trigger_flag;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_reg   <= tcrb_pkg::MODE_RESET;
			irq_en_reg <= 1'b0;
		end else if (wr_go) begin
			if (avs_req_in.address == tcrb_pkg::ADR_MODE) begin
				mode_reg <= {tcrb_pkg::MODE_RESV, avs_req_in.writedata[1:0]};
			end else if (avs_req_in.address == tcrb_pkg::ADR_IRQ_EN) begin
				irq_en_reg <= avs_req_in.writedata[tcrb_pkg::IRQ_EN_BIT];
			end
		end
	end

	// bus: one wait cycle, then data stands with waitrequest low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= ~((avs_req_in.read | avs_req_in.write) & wait_reg);
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= {tcrb_pkg::READ_PAD, tcrb_pkg::BYTE_ZERO};
		end else if (avs_req_in.read && wait_reg) begin
			if (avs_req_in.address == tcrb_pkg::ADR_CTRL) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, ctrl_reg};
			end else if (avs_req_in.address == tcrb_pkg::ADR_MODE) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, mode_reg};
			end else if (avs_req_in.address == tcrb_pkg::ADR_RLD_LOW) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, rld_low_reg};
			end else if (avs_req_in.address == tcrb_pkg::ADR_RLD_HIGH) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, rld_high_reg};
			end else if (avs_req_in.address == tcrb_pkg::ADR_CNT_LOW) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, cnt_reg[7:0]};
			end else if (avs_req_in.address == tcrb_pkg::ADR_CNT_HIGH) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, cnt_reg[15:8]};
			end else if (avs_req_in.address == tcrb_pkg::ADR_IRQ_EN) begin
				rdata_reg <= {tcrb_pkg::READ_PAD, 2'b00, irq_en_reg, 5'b0_0000};
			end else begin
				rdata_reg <= {tcrb_pkg::READ_PAD, tcrb_pkg::BYTE_ZERO};
			end
		end
	end

	// clock output pin; released (oe high) outside clock-out mode
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_o_reg <= 1'b0;
			oe_n_reg  <= 1'b1;
		end else begin
			oe_n_reg <= ~clk_out_mode;
			if (clk_out_mode && ovf_ev) begin
				clk_o_reg <= ~clk_o_reg;
			end
		end
	end

	// baud ticks and interrupt, all registered
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_tick_reg <= 1'b0;
			tx_tick_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			rx_tick_reg <= ctrl_reg.rx_baud_select ? ovf_ev : other_timer_ovf_in;
			tx_tick_reg <= ctrl_reg.tx_baud_select ? ovf_ev : other_timer_ovf_in;
			irq_reg <= irq_en_reg & (ctrl_reg.overflow_flag |
				(ctrl_reg.ext_trigger_flag & ~mode_reg.down_count_enable));
		end
	end

	assign avs_readdata_out    = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign ext_count_out       = clk_o_reg;
	assign ext_count_oe_n_out  = oe_n_reg;
	assign rx_baud_tick_out    = rx_tick_reg;
	assign tx_baud_tick_out    = tx_tick_reg;
	assign irq_out             = irq_reg;

	// assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_fall_enabled;
		trig_fall && ctrl_reg.ext_trigger_enable && !baud && !updown;
	endsequence

	sequence s_wrap_up;
		count_tick && !updown && cnt_reg == tcrb_pkg::CNT_MAX;
	endsequence

	AST_OVF_SETS: assert property (s_wrap_up and !baud |=> ctrl_reg.overflow_flag)
		else $error("overflow did not set flag");
	AST_OVF_BAUD: assert property (baud && !ctrl_reg.overflow_flag && !wr_go |=> !ctrl_reg.overflow_flag)
		else $error("flag set in baud mode");
	AST_TRIG_FLAG: assert property (s_fall_enabled |=> ctrl_reg.ext_trigger_flag)
		else $error("trigger flag not set");
	AST_IRQ_UPDOWN: assert property (mode_reg.down_count_enable && !ctrl_reg.overflow_flag |=> !irq_out)
		else $error("trigger flag raised irq in up/down");
	AST_RX_TICK: assert property (!ctrl_reg.rx_baud_select |=> rx_baud_tick_out == $past(other_timer_ovf_in))
		else $error("receive tick wrong source");
	AST_TX_TICK: assert property (ctrl_reg.tx_baud_select && ovf_ev |=> tx_baud_tick_out)
		else $error("transmit tick missing");
	AST_NO_TRIG: assert property (!ctrl_reg.ext_trigger_enable && !count_tick && !wr_go |=> $stable(cnt_reg))
		else $error("count moved while trigger disabled");
	AST_HALT: assert property (!ctrl_reg.run_control && !trig_ev && !wr_go |=> $stable(cnt_reg))
		else $error("count moved while halted");
	AST_CAPTURE: assert property (s_fall_enabled and ctrl_reg.capture_not_reload
		|=> {rld_high_reg, rld_low_reg} == $past(cnt_reg))
		else $error("capture lost");
	AST_RELOAD: assert property (s_wrap_up and (baud || !ctrl_reg.capture_not_reload) and !wr_go
		|=> cnt_reg == $past(rld))
		else $error("auto-reload missing");
	AST_IRQ_EN: assert property (!irq_en_reg |=> !irq_out)
		else $error("irq without enable");
	AST_IRQ_HOLD: assert property (irq_en_reg && ctrl_reg.overflow_flag |=> irq_out [*1])
		else $error("irq not held by flag");
	AST_BUS: assert property (avs_req_in.read && wait_reg |=> !avs_waitrequest_out)
		else $error("bus answer late");

	sequence s_step_down;
		count_tick && updown && !trig_s2_reg && cnt_reg != rld;
	endsequence

	sequence s_wrap_down;
		count_tick && updown && !trig_s2_reg && cnt_reg == rld;
	endsequence

	sequence s_pin_step;
		ctrl_reg.run_control && ctrl_reg.count_source_select && !trig_ev && !wr_go;
	endsequence

	AST_RX_BAUD: assert property (ctrl_reg.rx_baud_select && ovf_ev |=> rx_baud_tick_out)
		else $error("receive tick missing");
	AST_TRIG_BAUD: assert property (trig_fall && baud && !wr_go |=> $stable(rld))
		else $error("trigger acted in baud mode");
	AST_TRIG_OFF: assert property (
		!ctrl_reg.ext_trigger_enable && !ctrl_reg.ext_trigger_flag && !ovf_ev && !wr_go |=> !ctrl_reg.ext_trigger_flag)
		else $error("trigger flag set while disabled");
	AST_PIN_HOLD: assert property (s_pin_step and !cin_fall |=> $stable(cnt_reg))
		else $error("count moved without pin edge");
	AST_PIN_STEP: assert property (
		s_pin_step and cin_fall && !updown && cnt_reg != tcrb_pkg::CNT_MAX |=> cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("pin edge not counted");
	AST_CLK_OE: assert property (clk_out_mode |=> !ext_count_oe_n_out)
		else $error("clock pin not driven");
	AST_CLK_TOGGLE: assert property (clk_out_mode && ovf_ev |=> ext_count_out != $past(ext_count_out))
		else $error("clock out did not toggle");
	AST_DOWN: assert property (s_step_down and !wr_go |=> cnt_reg == $past(cnt_reg) - 16'h0001)
		else $error("down step wrong");
	AST_DOWN_WRAP: assert property (s_wrap_down and !wr_go |=> cnt_reg == tcrb_pkg::CNT_MAX)
		else $error("down wrap wrong");
	AST_RLD_LOW_WR: assert property (wr_go && !trig_ev && avs_req_in.address == tcrb_pkg::ADR_RLD_LOW
		|=> rld_low_reg == $past(avs_req_in.writedata[7:0]))
		else $error("reload low write lost");
	AST_RLD_HIGH_WR: assert property (wr_go && !trig_ev && avs_req_in.address == tcrb_pkg::ADR_RLD_HIGH
		|=> rld_high_reg == $past(avs_req_in.writedata[7:0]))
		else $error("reload high write lost");
	AST_CNT_LOW_WR: assert property (wr_go && avs_req_in.address == tcrb_pkg::ADR_CNT_LOW
		|=> cnt_reg[7:0] == $past(avs_req_in.writedata[7:0]))
		else $error("count low write lost");
	AST_CNT_HIGH_WR: assert property (wr_go && avs_req_in.address == tcrb_pkg::ADR_CNT_HIGH
		|=> cnt_reg[15:8] == $past(avs_req_in.writedata[7:0]))
		else $error("count high write lost");
	AST_TRIG_RELOAD: assert property (s_fall_enabled and !ctrl_reg.capture_not_reload && !wr_go
		|=> cnt_reg == $past(rld))
		else $error("trigger reload missing");
	AST_IRQ_TRIG: assert property (irq_en_reg && ctrl_reg.ext_trigger_flag && !mode_reg.down_count_enable
		|=> irq_out)
		else $error("trigger flag gave no irq");

endmodule

/* tb/tcrb_pins_model.sv */
/*
 pin-side partner: trigger pin, count pin and the other timer's overflow.
 assumes idle-high pins (pull-ups) and the shared clk_in.
*/
`timescale 1ns/1ps
module tcrb_pins_model (
	// clock
	input  wire logic clk_in,
	// pins and pulse
	output logic      trig_pin_out,
	output logic      cnt_pin_out,
	output logic      other_ovf_out
);
	initial begin
		trig_pin_out  = 1'b1;
		cnt_pin_out   = 1'b1;
		other_ovf_out = 1'b0;
	end
	// low phase outlasts the two-flop synchroniser
	task automatic trig_fall();
		trig_pin_out <= 1'b0;
		repeat (6) @(posedge clk_in);
		trig_pin_out <= 1'b1;
	endtask
	task automatic cnt_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			cnt_pin_out <= 1'b0;
			repeat (4) @(posedge clk_in);
			cnt_pin_out <= 1'b1;
			repeat (4) @(posedge clk_in);
		end
	endtask
	// level for the up/down direction input
	task automatic trig_level(input logic v);
		trig_pin_out <= v;
	endtask
	task automatic ovf_pulse();
		other_ovf_out <= 1'b1;
		@(posedge clk_in);
		other_ovf_out <= 1'b0;
	endtask
endmodule

/* tb/test_timer2_capture_reload_baud.sv */
/*
 self-checking bench for the capture/reload/baud timer.
 assumes the pin model as far side and avalon reads/writes via tasks.
*/
`timescale 1ns/1ps
module test_timer2_capture_reload_baud;
	typedef struct {
		logic [9:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} tcrb_row_t;
	logic                    clk_in = 1'b0;
	logic                    rst_n_in = 1'b0;
	tcrb_pkg::tcrb_avs_req_t req = '0;
	logic [31:0]             rdata;
	logic                    wreq, ecnt, oe_n, trig, cnt_pin, ovf, rxt, txt, irq;
	logic                    ec_l = 1'b0;
	logic [7:0]              q;
	wire logic               cnt_wire = oe_n ? cnt_pin : ecnt;
	int                      failures = 0, checks = 0, cycles = 0;
	int                      rx_n = 0, tx_n = 0, ec_n = 0, r0, t0, e0;
	tcrb_row_t rows[8] = '{
		'{tcrb_pkg::ADR_RLD_LOW, 8'hA5, 8'hA5}, '{tcrb_pkg::ADR_RLD_HIGH, 8'h5A, 8'h5A},
		'{tcrb_pkg::ADR_MODE, 8'hFF, 8'h03}, '{tcrb_pkg::ADR_CNT_LOW, 8'h3C, 8'h3C},
		'{tcrb_pkg::ADR_CNT_HIGH, 8'hC3, 8'hC3}, '{tcrb_pkg::ADR_IRQ_EN, 8'hFF, 8'h20},
		'{10'h3FC, 8'hFF, 8'h00}, '{tcrb_pkg::ADR_CTRL, 8'h00, 8'h00}};

	always #12.5 clk_in = ~clk_in;
	// pulse and toggle counters; values read here are those before the edge
	always @(posedge clk_in) begin
		cycles++;
		rx_n += rxt;
		tx_n += txt;
		ec_n += (ecnt != ec_l);
		ec_l = ecnt;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	tcrb_top dut_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_req_in(req), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .ext_trigger_pin_in(trig), .ext_count_input_in(cnt_wire),
		.ext_count_out(ecnt), .ext_count_oe_n_out(oe_n), .other_timer_ovf_in(ovf),
		.rx_baud_tick_out(rxt), .tx_baud_tick_out(txt), .irq_out(irq));
	tcrb_pins_model pins_u (
		.clk_in(clk_in), .trig_pin_out(trig), .cnt_pin_out(cnt_pin), .other_ovf_out(ovf));

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic r, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		req <= '{read: r, write: !r, address: a, writedata: 32'(d)};
		do begin
			@(posedge clk_in);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata[7:0];
		chk("bus answer", {7'h00, wreq}, 8'h00);
		req <= '0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rc(input string n, input logic [9:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00);
		chk(n, q, e);
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_in);
		chk("waitrequest in reset", {7'h00, wreq}, 8'h01);
		chk("irq in reset", {7'h00, irq}, 8'h00);
		chk("oe_n in reset", {7'h00, oe_n}, 8'h01);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		foreach (rows[i]) begin
			rc("reset value", rows[i].a, 8'h00);
			wr(rows[i].a, rows[i].d);
			rc("readback", rows[i].a, rows[i].e);
		end
		$display("done registers");
		wr(tcrb_pkg::ADR_MODE, 8'h00);
		wr(tcrb_pkg::ADR_CNT_HIGH, 8'hFF);
		wr(tcrb_pkg::ADR_CNT_LOW, 8'hFE);
		wr(tcrb_pkg::ADR_RLD_HIGH, 8'h12);
		wr(tcrb_pkg::ADR_RLD_LOW, 8'h34);
		wr(tcrb_pkg::ADR_CTRL, 8'h04);
		repeat (60) @(posedge clk_in);
		rc("ctrl after overflow", tcrb_pkg::ADR_CTRL, 8'h84);
		chk("irq on overflow", {7'h00, irq}, 8'h01);
		rc("count high reloaded", tcrb_pkg::ADR_CNT_HIGH, 8'h12);
		wr(tcrb_pkg::ADR_IRQ_EN, 8'h00);
		repeat (3) @(posedge clk_in);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wr(tcrb_pkg::ADR_IRQ_EN, 8'h20);
		wr(tcrb_pkg::ADR_CTRL, 8'h00);
		repeat (3) @(posedge clk_in);
		chk("irq after clear", {7'h00, irq}, 8'h00);
		wr(tcrb_pkg::ADR_CNT_LOW, 8'h10);
		repeat (50) @(posedge clk_in);
		rc("count held", tcrb_pkg::ADR_CNT_LOW, 8'h10);
		$display("done overflow");
		wr(tcrb_pkg::ADR_CNT_HIGH, 8'h77);
		wr(tcrb_pkg::ADR_RLD_HIGH, 8'h00);
		wr(tcrb_pkg::ADR_CTRL, 8'h0D);
		pins_u.trig_fall();
		repeat (10) @(posedge clk_in);
		rc("captured high", tcrb_pkg::ADR_RLD_HIGH, 8'h77);
		rc("ctrl after capture", tcrb_pkg::ADR_CTRL, 8'h4D);
		chk("irq on trigger", {7'h00, irq}, 8'h01);
		wr(tcrb_pkg::ADR_MODE, 8'h01);
		repeat (3) @(posedge clk_in);
		chk("irq in up/down", {7'h00, irq}, 8'h00);
		wr(tcrb_pkg::ADR_MODE, 8'h00);
		wr(tcrb_pkg::ADR_CTRL, 8'h05);
		wr(tcrb_pkg::ADR_RLD_HIGH, 8'h00);
		pins_u.trig_fall();
		repeat (10) @(posedge clk_in);
		rc("no capture disabled", tcrb_pkg::ADR_RLD_HIGH, 8'h00);
		rc("no flag disabled", tcrb_pkg::ADR_CTRL, 8'h05);
		$display("done capture");
		wr(tcrb_pkg::ADR_RLD_HIGH, 8'hFF);
		wr(tcrb_pkg::ADR_RLD_LOW, 8'hF0);
		wr(tcrb_pkg::ADR_CNT_HIGH, 8'hFF);
		wr(tcrb_pkg::ADR_CNT_LOW, 8'hF0);
		wr(tcrb_pkg::ADR_CTRL, 8'h1D);
		r0 = rx_n;
		t0 = tx_n;
		pins_u.ovf_pulse();
		pins_u.trig_fall();
		repeat (100) @(posedge clk_in);
		chk("tx ticks", {7'h00, tx_n != t0}, 8'h01);
		chk("rx from other timer", 8'(rx_n - r0), 8'h01);
		rc("ctrl in baud", tcrb_pkg::ADR_CTRL, 8'h1D);
		rc("baud reload high", tcrb_pkg::ADR_RLD_HIGH, 8'hFF);
		rc("count high in baud", tcrb_pkg::ADR_CNT_HIGH, 8'hFF);
		wr(tcrb_pkg::ADR_CTRL, 8'h24);
		r0 = rx_n;
		t0 = tx_n;
		repeat (60) @(posedge clk_in);
		chk("rx ticks", {7'h00, rx_n != r0}, 8'h01);
		chk("tx from other timer", 8'(tx_n - t0), 8'h00);
		$display("done baud");
		wr(tcrb_pkg::ADR_CTRL, 8'h04);
		wr(tcrb_pkg::ADR_MODE, 8'h02);
		repeat (3) @(posedge clk_in);
		chk("oe_n clock out", {7'h00, oe_n}, 8'h00);
		e0 = ec_n;
		repeat (40) @(posedge clk_in);
		chk("clock out toggles", {7'h00, ec_n != e0}, 8'h01);
		wr(tcrb_pkg::ADR_MODE, 8'h00);
		repeat (3) @(posedge clk_in);
		chk("oe_n released", {7'h00, oe_n}, 8'h01);
		wr(tcrb_pkg::ADR_CTRL, 8'h00);
		wr(tcrb_pkg::ADR_CNT_LOW, 8'h00);
		wr(tcrb_pkg::ADR_CTRL, 8'h06);
		pins_u.cnt_pulses(5);
		repeat (8) @(posedge clk_in);
		rc("pin edges counted", tcrb_pkg::ADR_CNT_LOW, 8'h05);
		$display("done clock out and count");
		wr(tcrb_pkg::ADR_CTRL, 8'h00);
		wr(tcrb_pkg::ADR_MODE, 8'h01);
		wr(tcrb_pkg::ADR_RLD_HIGH, 8'h00);
		wr(tcrb_pkg::ADR_RLD_LOW, 8'h00);
		wr(tcrb_pkg::ADR_CNT_HIGH, 8'h00);
		wr(tcrb_pkg::ADR_CNT_LOW, 8'h03);
		pins_u.trig_level(1'b0);
		wr(tcrb_pkg::ADR_CTRL, 8'h04);
		repeat (50) @(posedge clk_in);
		rc("count high after down wrap", tcrb_pkg::ADR_CNT_HIGH, 8'hFF);
		rc("ctrl after down wrap", tcrb_pkg::ADR_CTRL, 8'hC4);
		pins_u.trig_level(1'b1);
		wr(tcrb_pkg::ADR_MODE, 8'h00);
		$display("done down count");
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("waitrequest in mid-run reset", {7'h00, wreq}, 8'h01);
		chk("irq in mid-run reset", {7'h00, irq}, 8'h00);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rc("ctrl after mid-run reset", tcrb_pkg::ADR_CTRL, 8'h00);
		rc("count high after mid-run reset", tcrb_pkg::ADR_CNT_HIGH, 8'h00);
		$display("done reset");
		end_of_test();
	end
endmodule
